/* File: verilog/accel_cfg_device.sv */
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module accel_cfg_device #(
  parameter logic [31:0] SLEEP_UNIT_CYCLES = 32'(accel_cfg_pkg::SLEEP_UNIT_CYCLES)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register link
  reg_link_if.device link,
  // Sample and engine inputs
  input wire logic [2:0][15:0] filt_sample,
  input wire logic [2:0][15:0] raw_sample,
  input wire logic [7:0] engine_trig,
  input wire logic sample_done,
  // Decoded configuration
  output logic [3:0] span_code_q,
  output logic [2:0] bw_step_q,
  output accel_cfg_pkg::power_e power_q,
  output logic power_illegal_q,
  output logic [11:0] sleep_units_q,
  output logic second_variant_q,
  output logic equidistant_q,
  output logic fifo_access_q,
  output logic fifo_even_q,
  output logic [7:0] engine_en_q,
  output logic [7:0] engine_flag_q,
  output logic soft_reset_busy_q,
  output logic wake_q
);
  logic [7:0] span_q;
  logic [7:0] bw_q;
  logic [7:0] pwr_q;
  logic [7:0] duty_q;
  logic [7:0] fmt_q;
  logic [7:0] en0_q;
  logic ack_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [9:0] srst_cnt_q;
  logic srst_fire;
  logic take;
  logic wr;
  logic rd;
  logic in_deep;
  logic [2:0] lock_q;
  logic [2:0][7:0] hold_q;
  logic [2:0][15:0] sample;
  logic [2:0] rd_lsb;
  logic [2:0] rd_msb;
  logic [7:0] wval;

  assign take = link.req && !ack_q;
  assign wr = take && link.we;
  assign rd = take && !link.we;
  assign wval = link.wdata & accel_cfg_pkg::write_mask(link.addr);
  assign srst_fire = (srst_cnt_q == 10'h1);
  assign in_deep = (power_q == accel_cfg_pkg::PWR_DEEP);
  assign link.ack = ack_q;
  assign link.rdata = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Link handshake: one answer per request, one cycle later
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      ack_q <= take;
      if (rd)
        rdata_q <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration storage
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || srst_fire)
    begin
      span_q <= accel_cfg_pkg::DEF_SPAN;
      bw_q <= accel_cfg_pkg::DEF_BW;
      pwr_q <= accel_cfg_pkg::DEF_ZERO;
      duty_q <= accel_cfg_pkg::DEF_ZERO;
      fmt_q <= accel_cfg_pkg::DEF_ZERO;
      en0_q <= accel_cfg_pkg::DEF_ZERO;
    end
    else
    begin
      if (in_deep)
      begin
        // Settings are not kept through deep halt
        span_q <= accel_cfg_pkg::DEF_SPAN;
        bw_q <= accel_cfg_pkg::DEF_BW;
        duty_q <= accel_cfg_pkg::DEF_ZERO;
        fmt_q <= accel_cfg_pkg::DEF_ZERO;
        en0_q <= accel_cfg_pkg::DEF_ZERO;
      end
      else if (wr)
      begin
        case (link.addr)
          accel_cfg_pkg::OFS_SPAN: span_q <= wval;
          accel_cfg_pkg::OFS_BW: bw_q <= wval;
          accel_cfg_pkg::OFS_DUTY: duty_q <= wval;
          accel_cfg_pkg::OFS_FORMAT: fmt_q <= wval;
          accel_cfg_pkg::OFS_ENABLE0: en0_q <= wval;
          default: ;
        endcase
      end
      if (wr && link.addr == accel_cfg_pkg::OFS_POWER)
        pwr_q <= wval;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Soft reset command, delayed restore
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      srst_cnt_q <= 10'h0;
    else if (wr && link.addr == accel_cfg_pkg::OFS_RESET_CMD && link.wdata ==
             accel_cfg_pkg::RESET_KEY)
      srst_cnt_q <= accel_cfg_pkg::SOFT_RESET_CYCLES;
    else if (srst_cnt_q != 10'h0)
      srst_cnt_q <= srst_cnt_q - 10'h1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoded outputs
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      span_code_q <= 4'h0;
      bw_step_q <= 3'h0;
      power_q <= accel_cfg_pkg::PWR_NORMAL;
      power_illegal_q <= 1'b0;
      sleep_units_q <= 12'h001;
      second_variant_q <= 1'b0;
      equidistant_q <= 1'b0;
      fifo_access_q <= 1'b0;
      fifo_even_q <= 1'b0;
      engine_en_q <= 8'h00;
      soft_reset_busy_q <= 1'b0;
    end
    else
    begin
      span_code_q <= span_q[3:0];
      bw_step_q <= accel_cfg_pkg::bw_step(bw_q);
      power_illegal_q <= !accel_cfg_pkg::power_legal(pwr_q);
      if (accel_cfg_pkg::power_legal(pwr_q))
        power_q <= accel_cfg_pkg::power_decode(pwr_q);
      sleep_units_q <= accel_cfg_pkg::sleep_units(pwr_q[accel_cfg_pkg::SLEEP_LSB +: 4]);
      second_variant_q <= duty_q[accel_cfg_pkg::BIT_VARIANT];
      equidistant_q <= duty_q[accel_cfg_pkg::BIT_TIME_BASE];
      // Normal state always keeps the FIFO; halt and duty follow the variant
      fifo_access_q <= (power_q == accel_cfg_pkg::PWR_NORMAL) ||
        (power_q != accel_cfg_pkg::PWR_DEEP && duty_q[accel_cfg_pkg::BIT_VARIANT]);
      fifo_even_q <= (power_q == accel_cfg_pkg::PWR_NORMAL) ||
        (power_q == accel_cfg_pkg::PWR_DUTY && duty_q[accel_cfg_pkg::BIT_TIME_BASE]);
      engine_en_q <= en0_q;
      soft_reset_busy_q <= (srst_cnt_q != 10'h0);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Engine status flags, cleared by reading them
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || srst_fire)
      engine_flag_q <= 8'h00;
    else
      engine_flag_q <= ((rd && link.addr == accel_cfg_pkg::OFS_FLAGS) ? 8'h00 : engine_flag_q)
        | (engine_trig & en0_q & accel_cfg_pkg::MSK_ENABLE0);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sample output with per-axis high-byte lock
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_axis
      assign sample[g] = fmt_q[accel_cfg_pkg::BIT_BYPASS] ? raw_sample[g] : filt_sample[g];
      assign rd_lsb[g] = rd && link.addr == accel_cfg_pkg::OFS_DATA_LSB + 8'(2 * g);
      assign rd_msb[g] = rd && link.addr == accel_cfg_pkg::OFS_DATA_LSB + 8'(2 * g + 1);
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst || fmt_q[accel_cfg_pkg::BIT_SHADOW_DIS])
        begin
          lock_q[g] <= 1'b0;
          hold_q[g] <= 8'h00;
        end
        else if (rd_lsb[g])
        begin
          lock_q[g] <= 1'b1;
          hold_q[g] <= sample[g][15:8];
        end
        else if (rd_msb[g])
          lock_q[g] <= 1'b0;
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb
  begin
    rdata_d = 8'h00;
    case (link.addr)
      accel_cfg_pkg::OFS_FLAGS: rdata_d = engine_flag_q;
      accel_cfg_pkg::OFS_SPAN: rdata_d = span_q;
      accel_cfg_pkg::OFS_BW: rdata_d = bw_q;
      accel_cfg_pkg::OFS_POWER: rdata_d = pwr_q;
      accel_cfg_pkg::OFS_DUTY: rdata_d = duty_q;
      accel_cfg_pkg::OFS_FORMAT: rdata_d = fmt_q;
      accel_cfg_pkg::OFS_ENABLE0: rdata_d = en0_q;
      default:
      begin
        for (int i = 0; i < 3; i++)
        begin
          if (link.addr == accel_cfg_pkg::OFS_DATA_LSB + 8'(2 * i))
            rdata_d = sample[i][7:0];
          if (link.addr == accel_cfg_pkg::OFS_DATA_LSB + 8'(2 * i + 1))
            rdata_d = lock_q[i] ? hold_q[i] : sample[i][15:8];
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Duty-cycle sleep phase
  sleep_timer #(
    .UNIT_CYCLES(SLEEP_UNIT_CYCLES)
  ) u_sleep (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .run(power_q == accel_cfg_pkg::PWR_DUTY),
    .equidistant(equidistant_q),
    .sample_done(sample_done),
    .units(sleep_units_q),
    .wake_q(wake_q)
  );
endmodule : accel_cfg_device
`default_nettype wire

/* File: verilog/accel_cfg_pkg.sv */
`default_nettype none
package accel_cfg_pkg;
  // Register indices on the link
  localparam logic [7:0] OFS_DATA_LSB = 8'h02;
  localparam logic [7:0] OFS_FLAGS = 8'h09;
  localparam logic [7:0] OFS_SPAN = 8'h0f;
  localparam logic [7:0] OFS_BW = 8'h10;
  localparam logic [7:0] OFS_POWER = 8'h11;
  localparam logic [7:0] OFS_DUTY = 8'h12;
  localparam logic [7:0] OFS_FORMAT = 8'h13;
  localparam logic [7:0] OFS_RESET_CMD = 8'h14;
  localparam logic [7:0] OFS_ENABLE0 = 8'h16;
  // Reset values and writable-bit masks
  localparam logic [7:0] DEF_SPAN = 8'h03;
  localparam logic [7:0] DEF_BW = 8'h0f;
  localparam logic [7:0] DEF_ZERO = 8'h00;
  localparam logic [7:0] MSK_SPAN = 8'h0f;
  localparam logic [7:0] MSK_BW = 8'h1f;
  localparam logic [7:0] MSK_POWER = 8'hfe;
  localparam logic [7:0] MSK_DUTY = 8'h60;
  localparam logic [7:0] MSK_FORMAT = 8'hc0;
  localparam logic [7:0] MSK_ENABLE0 = 8'hf7;
  localparam logic [7:0] RESET_KEY = 8'hb6;
  // Field positions
  localparam int BIT_HALT = 7;
  localparam int BIT_DUTY_EN = 6;
  localparam int BIT_DEEP = 5;
  localparam int SLEEP_LSB = 1;
  localparam int BIT_VARIANT = 6;
  localparam int BIT_TIME_BASE = 5;
  localparam int BIT_BYPASS = 7;
  localparam int BIT_SHADOW_DIS = 6;
  // Host-side APB register map
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam int CMD_WRITE_BIT = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_REPROGRAM = 2;
  // Timing
  localparam int CLK_NS = 4;
  localparam int SLEEP_UNIT_NS = 500000;
  localparam int SLEEP_UNIT_CYCLES = SLEEP_UNIT_NS / CLK_NS;
  localparam int SOFT_RESET_DELAY_NS = 2000;
  localparam logic [9:0] SOFT_RESET_CYCLES = 10'((SOFT_RESET_DELAY_NS + CLK_NS - 1) / CLK_NS);
  localparam int SLOW_WRITE_GAP_NS = 1000;
  localparam logic [9:0] SLOW_WRITE_CYCLES = 10'((SLOW_WRITE_GAP_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_DEEP = 2'b01,
    PWR_DUTY = 2'b10,
    PWR_HALT = 2'b11
  } power_e;

  // Bandwidth step 0 = 7.81 Hz ... 7 = 1000 Hz
  function automatic logic [2:0] bw_step(input logic [7:0] bw);
    if (bw[4])
      bw_step = 3'h7;
    else if (!bw[3])
      bw_step = 3'h0;
    else
      bw_step = bw[2:0];
  endfunction : bw_step

  // Sleep length in units of half a millisecond
  function automatic logic [11:0] sleep_units(input logic [3:0] code);
    case (code)
      4'h6: sleep_units = 12'h002;
      4'h7: sleep_units = 12'h004;
      4'h8: sleep_units = 12'h008;
      4'h9: sleep_units = 12'h00c;
      4'ha: sleep_units = 12'h014;
      4'hb: sleep_units = 12'h032;
      4'hc: sleep_units = 12'h064;
      4'hd: sleep_units = 12'h0c8;
      4'he: sleep_units = 12'h3e8;
      4'hf: sleep_units = 12'h7d0;
      default: sleep_units = 12'h001;
    endcase
  endfunction : sleep_units

  function automatic logic power_legal(input logic [7:0] v);
    power_legal = (32'(v[BIT_HALT]) + 32'(v[BIT_DUTY_EN]) + 32'(v[BIT_DEEP])) <= 1;
  endfunction : power_legal

  function automatic power_e power_decode(input logic [7:0] v);
    if (v[BIT_HALT])
      power_decode = PWR_HALT;
    else if (v[BIT_DUTY_EN])
      power_decode = PWR_DUTY;
    else if (v[BIT_DEEP])
      power_decode = PWR_DEEP;
    else
      power_decode = PWR_NORMAL;
  endfunction : power_decode

  function automatic logic [7:0] write_mask(input logic [7:0] ofs);
    case (ofs)
      OFS_SPAN: write_mask = MSK_SPAN;
      OFS_BW: write_mask = MSK_BW;
      OFS_POWER: write_mask = MSK_POWER;
      OFS_DUTY: write_mask = MSK_DUTY;
      OFS_FORMAT: write_mask = MSK_FORMAT;
      OFS_ENABLE0: write_mask = MSK_ENABLE0;
      default: write_mask = 8'hff;
    endcase
  endfunction : write_mask
endpackage : accel_cfg_pkg
`default_nettype wire

/* File: verilog/reg_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface reg_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  modport device (input req, input we, input addr, input wdata, output rdata, output ack);
  modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface : reg_link_if
`default_nettype wire

/* File: verilog/sleep_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module sleep_timer #(
  parameter logic [31:0] UNIT_CYCLES = 32'(accel_cfg_pkg::SLEEP_UNIT_CYCLES)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  input wire logic equidistant,
  input wire logic sample_done,
  input wire logic [11:0] units,
  // Wake pulse
  output logic wake_q
);
  logic [31:0] cnt_q;
  logic waiting_q;
  logic [31:0] target;

  assign target = 32'(32'(units) * UNIT_CYCLES);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !run)
    begin
      cnt_q <= 32'h0;
      wake_q <= 1'b0;
      waiting_q <= 1'b0;
    end
    else if (waiting_q)
    begin
      // Event-driven: sleep restarts only after the sample finishes
      wake_q <= 1'b0;
      waiting_q <= !sample_done;
    end
    else if (cnt_q + 32'h1 >= target)
    begin
      cnt_q <= 32'h0;
      wake_q <= 1'b1;
      waiting_q <= !equidistant;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h1;
      wake_q <= 1'b0;
    end
  end
endmodule : sleep_timer
`default_nettype wire

/* File: verilog/accel_cfg_host.sv */
`timescale 1ns/1ps
`default_nettype none
module accel_cfg_host (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // Register link
  reg_link_if.host link
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_GAP = 2'b01,
    H_REQ = 2'b10
  } host_state_e;

  host_state_e state_q;
  logic req_q;
  logic we_q;
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic refused_q;
  logic reprogram_q;
  logic [9:0] gap_q;
  logic [7:0] pwr_shadow_q;
  logic second_q;
  logic commit;
  logic cmd_go;
  logic cmd_ok;
  logic done;
  logic slow;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_data;
  accel_cfg_pkg::power_e cur_pwr;
  accel_cfg_pkg::power_e new_pwr;

  assign link.req = req_q;
  assign link.we = we_q;
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign commit = psel && penable && pready_q && pwrite;
  assign cmd_go = commit && paddr == accel_cfg_pkg::APB_CMD;
  assign cmd_addr = pwdata[7:0];
  assign cmd_data = pwdata[15:8] & accel_cfg_pkg::write_mask(cmd_addr);
  assign cur_pwr = accel_cfg_pkg::power_decode(pwr_shadow_q);
  assign new_pwr = accel_cfg_pkg::power_decode(cmd_data);
  assign done = state_q == H_REQ && link.ack;
  assign slow = !second_q && cur_pwr != accel_cfg_pkg::PWR_NORMAL;

  // Only moves that pass through normal, or stay put, are sent
  always_comb
  begin
    cmd_ok = state_q == H_IDLE;
    if (pwdata[accel_cfg_pkg::CMD_WRITE_BIT] && cmd_addr == accel_cfg_pkg::OFS_POWER)
      cmd_ok = cmd_ok && accel_cfg_pkg::power_legal(cmd_data) && (new_pwr == cur_pwr ||
        new_pwr == accel_cfg_pkg::PWR_NORMAL || cur_pwr == accel_cfg_pkg::PWR_NORMAL);
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state on every access
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= paddr != accel_cfg_pkg::APB_CMD && paddr != accel_cfg_pkg::APB_STATUS;
      prdata_q <= 32'h0;
      if (paddr == accel_cfg_pkg::APB_CMD)
        prdata_q <= {15'h0, we_q, wdata_q, addr_q};
      else if (paddr == accel_cfg_pkg::APB_STATUS)
        prdata_q <= {16'h0, rdata_q, 5'h0, reprogram_q, refused_q, state_q != H_IDLE};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link transfer sequence
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_q <= H_IDLE;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      gap_q <= 10'h0;
    end
    else
    begin
      if (gap_q != 10'h0)
        gap_q <= gap_q - 10'h1;
      case (state_q)
        H_IDLE:
        begin
          if (cmd_go && cmd_ok)
          begin
            we_q <= pwdata[accel_cfg_pkg::CMD_WRITE_BIT];
            addr_q <= cmd_addr;
            wdata_q <= cmd_data;
            state_q <= H_GAP;
          end
        end
        H_GAP:
        begin
          if (gap_q == 10'h0 || !we_q)
          begin
            req_q <= 1'b1;
            state_q <= H_REQ;
          end
        end
        H_REQ:
        begin
          if (link.ack)
          begin
            req_q <= 1'b0;
            rdata_q <= link.rdata;
            state_q <= H_IDLE;
            if (we_q && slow)
              gap_q <= accel_cfg_pkg::SLOW_WRITE_CYCLES;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Device state shadow and sticky status
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pwr_shadow_q <= accel_cfg_pkg::DEF_ZERO;
      second_q <= 1'b0;
      refused_q <= 1'b0;
      reprogram_q <= 1'b0;
    end
    else
    begin
      if (commit && paddr == accel_cfg_pkg::APB_STATUS)
      begin
        if (pwdata[accel_cfg_pkg::ST_REFUSED])
          refused_q <= 1'b0;
        if (pwdata[accel_cfg_pkg::ST_REPROGRAM])
          reprogram_q <= 1'b0;
      end
      if (cmd_go && !cmd_ok)
        refused_q <= 1'b1;
      if (done && we_q)
      begin
        if (addr_q == accel_cfg_pkg::OFS_POWER)
        begin
          pwr_shadow_q <= wdata_q;
          if (cur_pwr == accel_cfg_pkg::PWR_DEEP)
            reprogram_q <= 1'b1;
        end
        if (addr_q == accel_cfg_pkg::OFS_DUTY)
          second_q <= wdata_q[accel_cfg_pkg::BIT_VARIANT];
        if (addr_q == accel_cfg_pkg::OFS_RESET_CMD && wdata_q == accel_cfg_pkg::RESET_KEY)
        begin
          pwr_shadow_q <= accel_cfg_pkg::DEF_ZERO;
          second_q <= 1'b0;
          reprogram_q <= 1'b1;
        end
      end
    end
  end
endmodule : accel_cfg_host
`default_nettype wire

/* File: verif/link_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module link_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Link
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  // Device state
  input wire logic [3:0] span_code_q,
  input wire logic [2:0] bw_step_q,
  input wire accel_cfg_pkg::power_e power_q,
  input wire logic equidistant_q,
  input wire logic fifo_even_q,
  input wire logic [7:0] engine_trig,
  input wire logic [7:0] engine_en_q,
  input wire logic [7:0] engine_flag_q,
  input wire logic soft_reset_busy_q,
  input wire logic wake_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  a_ack_one_late: assert property (req && !ack |=> ack)
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_req_held: assert property (req && !ack |=> req && $stable(addr) && $stable(we)
    && $stable(wdata))
    else $error("request changed before ack");
  a_req_drop: assert property (ack |=> !req)
    else $error("request not dropped after ack");
  // Enable output lags the stored enable by one cycle
  a_flag_enabled: assert property ((engine_flag_q & ~$past(engine_flag_q)
    & ~($past(engine_trig) & engine_en_q)) == 8'h00)
    else $error("flag set without enabled trigger");
  a_key_starts: assert property (req && !ack && we
    && addr == accel_cfg_pkg::OFS_RESET_CMD
    && wdata == accel_cfg_pkg::RESET_KEY |-> ##[1:3] soft_reset_busy_q)
    else $error("reset key did not start reset");
  a_reset_restores: assert property ($fell(soft_reset_busy_q)
    |-> ##[0:2] span_code_q == 4'h3 && bw_step_q == 3'h7)
    else $error("defaults not restored");
  a_span_default: assert property ($fell(sys_rst)
    |-> ##[0:1] span_code_q == 4'h3 && bw_step_q == 3'h7)
    else $error("wrong decode after reset");
  a_wake_in_duty: assert property (wake_q
    |-> power_q == accel_cfg_pkg::PWR_DUTY || $past(power_q) == accel_cfg_pkg::PWR_DUTY)
    else $error("wake outside duty state");
  a_even_base: assert property (fifo_even_q && $stable(power_q)
    && $stable(equidistant_q) |-> power_q == accel_cfg_pkg::PWR_NORMAL
    || (power_q == accel_cfg_pkg::PWR_DUTY && equidistant_q))
    else $error("even spacing claimed wrongly");
endmodule : link_sva
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk, sys_rst, psel, penable, pwrite, pready_q, pslverr_q, sample_done;
  logic [7:0] paddr, engine_trig;
  logic [31:0] pwdata, prdata_q, s;
  logic [2:0][15:0] filt_sample, raw_sample;
  logic [3:0] span_code_q;
  logic [2:0] bw_step_q;
  accel_cfg_pkg::power_e power_q;
  logic second_variant_q, equidistant_q, fifo_access_q, fifo_even_q, soft_reset_busy_q, wake_q;
  logic [11:0] sleep_units_q;
  logic [7:0] engine_en_q, engine_flag_q;
  logic [7:0] tv[6];
  logic [7:0] te[6];
  int bad_count, checks, n;
  ////////////////////////////////////////////////////////////////
  reg_link_if link();
  accel_cfg_device #(.SLEEP_UNIT_CYCLES(32'd4)) i_accel_cfg_device (.sys_clk, .sys_rst,
    .link(link), .filt_sample, .raw_sample, .engine_trig, .sample_done, .span_code_q,
    .bw_step_q, .power_q, .power_illegal_q(), .sleep_units_q, .second_variant_q,
    .equidistant_q, .fifo_access_q, .fifo_even_q, .engine_en_q, .engine_flag_q,
    .soft_reset_busy_q, .wake_q);
  accel_cfg_host i_accel_cfg_host (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata_q, .pready_q, .pslverr_q, .link(link));
  link_sva i_link_sva (.sys_clk, .sys_rst, .req(link.req), .we(link.we), .addr(link.addr),
    .wdata(link.wdata), .ack(link.ack), .span_code_q, .bw_step_q, .power_q, .equidistant_q,
    .fifo_even_q, .engine_trig, .engine_en_q, .engine_flag_q, .soft_reset_busy_q, .wake_q);
  ////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task close_out;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // One APB transfer; read data lands in s
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready_q !== 1'b1 && k < 50);
    s = prdata_q;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50)
    begin
      bad_count++;
      close_out();
    end
  endtask : apb

  // Link command, then poll until the host is idle
  task cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, accel_cfg_pkg::APB_CMD, {15'h0, w, d, a});
    n = 0;
    do
    begin
      apb(1'b0, accel_cfg_pkg::APB_STATUS, 32'h0);
      n++;
    end
    while (s[accel_cfg_pkg::ST_BUSY] !== 1'b0 && n < 200);
    if (n >= 200)
    begin
      bad_count++;
      close_out();
    end
  endtask : cmd

  task wr(input logic [7:0] a, input logic [7:0] d);
    cmd(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    cmd(1'b0, a, 8'h00);
    chk(s[15:8], e);
  endtask : rd

  task trig(input logic [7:0] t);
    @(posedge sys_clk);
    engine_trig <= t;
    @(posedge sys_clk);
    engine_trig <= 8'h00;
  endtask : trig

  initial
  begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sample_done = 1'b0;
    engine_trig = 8'h00;
    filt_sample = {16'h0, 16'h0, 16'h1234};
    raw_sample = {16'h0, 16'h0, 16'h5678};
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tv = '{accel_cfg_pkg::OFS_SPAN, accel_cfg_pkg::OFS_BW, accel_cfg_pkg::OFS_POWER,
      accel_cfg_pkg::OFS_DUTY, accel_cfg_pkg::OFS_FORMAT, accel_cfg_pkg::OFS_ENABLE0};
    te = '{8'h03, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++)
      rd(tv[i], te[i]);
    rd(accel_cfg_pkg::OFS_RESET_CMD, 8'h00);
    tv = '{8'h03, 8'h05, 8'h08, 8'h0c, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++)
    begin
      wr(accel_cfg_pkg::OFS_SPAN, tv[i]);
      chk({4'h0, span_code_q}, tv[i]);
    end
    tv = '{8'h05, 8'h08, 8'h0b, 8'h0d, 8'h0f, 8'h13};
    te = '{8'h00, 8'h00, 8'h03, 8'h05, 8'h07, 8'h07};
    for (int i = 0; i < 6; i++)
    begin
      wr(accel_cfg_pkg::OFS_BW, tv[i]);
      chk({5'h0, bw_step_q}, te[i]);
    end
    wr(accel_cfg_pkg::OFS_ENABLE0, 8'h05);
    trig(8'hff);
    rd(accel_cfg_pkg::OFS_FLAGS, 8'h05);
    wr(accel_cfg_pkg::OFS_ENABLE0, 8'hf7);
    rd(accel_cfg_pkg::OFS_ENABLE0, 8'hf7);
    trig(8'hff);
    rd(accel_cfg_pkg::OFS_FLAGS, 8'hf7);
    rd(accel_cfg_pkg::OFS_DATA_LSB, 8'h34);
    filt_sample[0] <= 16'hab34;
    rd(accel_cfg_pkg::OFS_DATA_LSB + 8'h01, 8'h12);
    rd(accel_cfg_pkg::OFS_DATA_LSB + 8'h01, 8'hab);
    wr(accel_cfg_pkg::OFS_FORMAT, 8'h80);
    rd(accel_cfg_pkg::OFS_DATA_LSB, 8'h78);
    rd(accel_cfg_pkg::OFS_DATA_LSB + 8'h01, 8'h56);
    wr(accel_cfg_pkg::OFS_FORMAT, 8'hc0);
    rd(accel_cfg_pkg::OFS_DATA_LSB, 8'h78);
    raw_sample[0] <= 16'hcd78;
    rd(accel_cfg_pkg::OFS_DATA_LSB + 8'h01, 8'hcd);
    wr(accel_cfg_pkg::OFS_RESET_CMD, 8'h55);
    chk({7'h0, soft_reset_busy_q}, 8'h00);
    rd(accel_cfg_pkg::OFS_SPAN, 8'h0c);
    apb(1'b0, 8'h08, 32'h0);
    chk({7'h0, pslverr_q}, 8'h01);
    wr(accel_cfg_pkg::OFS_DUTY, 8'h60);
    wr(accel_cfg_pkg::OFS_POWER, 8'h4c);
    chk({6'h0, power_q}, {6'h0, accel_cfg_pkg::PWR_DUTY});
    chk({4'h0, second_variant_q, equidistant_q, fifo_access_q, fifo_even_q}, 8'h0f);
    chk(sleep_units_q[7:0], 8'h02);
    n = 0;
    while (wake_q !== 1'b1 && n < 100)
    begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wake_q !== 1'b1 && n < 100);
    chk(8'(n), 8'h08);
    // Event-driven base: no wake until a sample completes
    wr(accel_cfg_pkg::OFS_DUTY, 8'h40);
    repeat (10) @(posedge sys_clk);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge sys_clk);
      sample_done <= 1'(i);
      n = 0;
      repeat (12)
      begin
        @(posedge sys_clk);
        sample_done <= 1'b0;
        n += int'(wake_q);
      end
      chk(8'(n), 8'(i));
    end
    wr(accel_cfg_pkg::OFS_RESET_CMD, 8'hb6);
    chk({7'h0, soft_reset_busy_q}, 8'h01);
    repeat (520) @(posedge sys_clk);
    chk({6'h0, power_q}, {6'h0, accel_cfg_pkg::PWR_NORMAL});
    rd(accel_cfg_pkg::OFS_SPAN, 8'h03);
    chk({7'h0, s[accel_cfg_pkg::ST_REPROGRAM]}, 8'h01);
    apb(1'b1, accel_cfg_pkg::APB_STATUS, 32'h6);
    wr(accel_cfg_pkg::OFS_POWER, 8'h80);
    chk({4'h0, power_q, fifo_access_q, 1'b0}, {4'h0, accel_cfg_pkg::PWR_HALT, 2'b00});
    wr(accel_cfg_pkg::OFS_POWER, 8'hc0);
    chk({7'h0, s[accel_cfg_pkg::ST_REFUSED]}, 8'h01);
    apb(1'b1, accel_cfg_pkg::APB_STATUS, 32'h6);
    wr(accel_cfg_pkg::OFS_POWER, 8'h40);
    chk({5'h0, s[accel_cfg_pkg::ST_REFUSED], power_q}, {5'h0, 1'b1, accel_cfg_pkg::PWR_HALT});
    wr(accel_cfg_pkg::OFS_POWER, 8'h00);
    wr(accel_cfg_pkg::OFS_SPAN, 8'h0c);
    wr(accel_cfg_pkg::OFS_POWER, 8'h20);
    chk({6'h0, power_q}, {6'h0, accel_cfg_pkg::PWR_DEEP});
    wr(accel_cfg_pkg::OFS_SPAN, 8'h0c);
    wr(accel_cfg_pkg::OFS_POWER, 8'h00);
    rd(accel_cfg_pkg::OFS_SPAN, 8'h03);
    chk({7'h0, s[accel_cfg_pkg::ST_REPROGRAM]}, 8'h01);
    close_out();
  end
endmodule : testbench
`default_nettype wire
